// file: hw/sfpm_pkg.sv
// package for the switch fault protection manager
package sfpm_pkg;
    localparam int unsigned SFPM_CLK_HZ = 20000000;
    // autoretry period in microseconds
    localparam int unsigned SFPM_T_AUTO_US = 150000;
    localparam longint unsigned SFPM_AUTO_CYC_L = (longint'(SFPM_T_AUTO_US) * SFPM_CLK_HZ) / 1000000;
    localparam int unsigned SFPM_AUTO_CYC = int'(SFPM_AUTO_CYC_L);
    localparam int unsigned SFPM_RETRY_MAX = 16;
    // number of current levels in a profile
    localparam int unsigned SFPM_NUM_STEPS = 8;
    // inrush step dwell base in cycles, scaled by slope field
    localparam int unsigned SFPM_STEP_BASE = 256;
    // cooling emulator base per off-duration unit in cycles
    localparam int unsigned SFPM_COOL_BASE = 1024;
    // steady level index for each steady_level_select code (second level default), then the inrush top and skip steps
    localparam logic [2:0] SFPM_LVL_DC1 = 3'h4;
    localparam logic [2:0] SFPM_LVL_DC2 = 3'h5;
    localparam logic [2:0] SFPM_LVL_DC3 = 3'h6;
    localparam logic [2:0] SFPM_LVL_DC4 = 3'h7;
    localparam logic [2:0] SFPM_LVL_TOP = 3'h0;
    localparam logic [2:0] SFPM_LVL_SKIP = 3'h1;

    typedef enum logic [2:0] {
        SFPM_MODE_NORMAL = 3'b001,
        SFPM_MODE_FAILSAFE = 3'b010,
        SFPM_MODE_OFF = 3'b100
    } sfpm_mode_t;

    // per-channel configuration bits
    typedef struct packed {
        logic hid_profile_select;
        logic bulb28_select;
        logic [1:0] inrush_slope;
        logic inrush_top_step_remove;
        logic [1:0] steady_level_select;
        logic cooling_emulation_enable;
        logic [1:0] cooling_slope_select;
        logic short_to_supply_disable;
        logic off_openload_disable;
        logic direct_disable;
        logic on_bit;
    } sfpm_ch_cfg_t;

    // per-channel comparator results
    typedef struct packed {
        logic overtemp;
        logic overcurrent;
        logic severe_short;
        logic short_to_supply;
        logic off_openload;
        logic gate_off;
    } sfpm_ch_det_t;

    // reported status bits per channel
    typedef struct packed {
        logic overtemp_flag;
        logic overcurrent_flag;
        logic severe_short_flag;
        logic short_to_supply_flag;
        logic off_openload_flag;
    } sfpm_ch_stat_t;
endpackage

// file: hw/sfpm_top.sv
// fault protection and diagnostic manager for a four-channel high-side switch
`timescale 1ns/1ps
module sfpm_top
    import sfpm_pkg::*;
#(
    parameter int unsigned NCH = 4,
    parameter int unsigned AUTO_CYC = SFPM_AUTO_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic logic_supply_fail,
    input wire logic [NCH-1:0] on_input,
    input wire logic pwm_enable,
    input wire logic internal_pwm_select,
    input wire logic failsafe_mode,
    input wire logic overvoltage_protect_disable,
    input wire sfpm_ch_cfg_t [NCH-1:0] ch_cfg,
    input wire sfpm_ch_det_t [NCH-1:0] ch_det,
    input wire logic overvoltage_det,
    input wire logic undervoltage_det,
    input wire logic status_read,
    output logic [NCH-1:0] output_enable,
    output logic [NCH-1:0][2:0] oc_level_index,
    output logic fault_flag_out_n,
    output sfpm_ch_stat_t [NCH-1:0] ch_stat,
    output logic overvoltage_flag,
    output logic undervoltage_flag,
    output logic [NCH-1:0][4:0] retry_count
);
    // refuse sizes that the counters and the pin logic cannot serve
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
        $error("sfpm_top: NCH out of range");
    end
    if (AUTO_CYC < 1) begin : g_bad_auto
        $error("sfpm_top: AUTO_CYC must be positive");
    end

    localparam int AW = $clog2(AUTO_CYC + 1);
    localparam logic [4:0] RMAX = 5'(SFPM_RETRY_MAX);
    localparam logic [AW-1:0] AUTO_LAST = AW'(AUTO_CYC - 1);
    // first inrush step for a hot and for a warm filament
    localparam logic [2:0] STEP_HOT = 3'h3;
    localparam logic [2:0] STEP_WARM = 3'h2;

    // comparator inputs come from analog, so resynchronise everything
    logic [NCH*6+2-1:0] det_s1_r, det_s2_r;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            det_s1_r <= '0;
            det_s2_r <= '0;
        end else begin
            det_s1_r <= {ch_det, overvoltage_det, undervoltage_det};
            det_s2_r <= det_s1_r;
        end
    end
    sfpm_ch_det_t [NCH-1:0] det;
    logic ov_s, uv_s;
    assign det = det_s2_r[NCH*6+1:2];
    assign ov_s = det_s2_r[1];
    assign uv_s = det_s2_r[0];

    // supply-fail acts as a synchronous wipe of every latch
    logic wipe;
    assign wipe = logic_supply_fail;

    // mode tracking for retry counter reset
    sfpm_mode_t mode_r;
    logic mode_change;
    sfpm_mode_t mode_nxt;
    always_comb begin
        mode_nxt = failsafe_mode ? SFPM_MODE_FAILSAFE : SFPM_MODE_NORMAL;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) mode_r <= SFPM_MODE_OFF;
        else mode_r <= mode_nxt;
    end
    assign mode_change = (mode_r != mode_nxt) && (mode_r != SFPM_MODE_OFF);

    // overvoltage shutdown and shared undervoltage latch
    logic uv_lat_r;
    logic ov_shut;
    logic any_cmd;
    logic [NCH-1:0] cmd;
    logic [NCH-1:0] retry_fire_v;
    assign ov_shut = ov_s && !overvoltage_protect_disable;
    assign any_cmd = |cmd;
    // a retry on any channel releases the shared latch, else a commanded output could never restart
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) uv_lat_r <= 1'b0;
        else if (wipe || mode_change) uv_lat_r <= 1'b0;
        else if (uv_s) uv_lat_r <= 1'b1;
        else if (!any_cmd || (|retry_fire_v)) uv_lat_r <= 1'b0;
    end

    // status flags for supply faults; set beats read clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            overvoltage_flag <= 1'b0;
            undervoltage_flag <= 1'b0;
        end else if (wipe) begin
            overvoltage_flag <= 1'b0;
            undervoltage_flag <= 1'b0;
        end else begin
            if (ov_s) overvoltage_flag <= 1'b1;
            else if (status_read) overvoltage_flag <= 1'b0;
            if (uv_s) undervoltage_flag <= 1'b1;
            else if (status_read) undervoltage_flag <= 1'b0;
        end
    end

    // per-channel requests to pull the fault pin low
    logic [NCH-1:0] pin_low;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic cmd_d_r, lat_ot_r, lat_oc_r, lat_sc_r, inrush_r, retry_req;
            logic [2:0] step_r;
            logic [11:0] dwell_r;
            logic [15:0] off_cnt_r;
            logic [AW-1:0] auto_cnt_r;
            logic retry_fire, rise, fall, stable_on, latched;
            logic [11:0] dwell_len;
            logic [2:0] first_step, steady_lvl, prof_ofs;

            // output command selection
            assign cmd[g] = pwm_enable ? ch_cfg[g].on_bit
                          : (on_input[g] && !ch_cfg[g].direct_disable);
            assign rise = cmd[g] && !cmd_d_r;
            assign fall = !cmd[g] && cmd_d_r;
            assign latched = lat_ot_r || lat_oc_r || lat_sc_r || uv_lat_r;
            // retry request; a status read drops it, so a read stops further retries
            assign retry_req = ch_stat[g].overcurrent_flag || ch_stat[g].overtemp_flag
                             || undervoltage_flag;
            assign retry_fire = retry_req && latched && !lat_sc_r && cmd[g]
                              && !det[g].overtemp && !uv_s
                              && (retry_count[g] < RMAX) && (auto_cnt_r == AUTO_LAST);
            assign retry_fire_v[g] = retry_fire;

            // delayed command; a command high at release reads as a rise and starts inrush
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) cmd_d_r <= 1'b0;
                else cmd_d_r <= cmd[g];
            end

            // protection latches; the off-then-on toggle is the command's falling edge
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    lat_ot_r <= 1'b0;
                    lat_oc_r <= 1'b0;
                    lat_sc_r <= 1'b0;
                end else if (wipe || mode_change) begin
                    lat_ot_r <= 1'b0;
                    lat_oc_r <= 1'b0;
                    lat_sc_r <= 1'b0;
                end else begin
                    if (det[g].overtemp && cmd[g]) lat_ot_r <= 1'b1;
                    else if (!det[g].overtemp && (fall || retry_fire)) lat_ot_r <= 1'b0;
                    if (det[g].overcurrent && output_enable[g]) lat_oc_r <= 1'b1;
                    else if (!det[g].overcurrent && (fall || retry_fire)) lat_oc_r <= 1'b0;
                    if (det[g].severe_short && output_enable[g]) lat_sc_r <= 1'b1;
                    else if (!det[g].severe_short && fall) lat_sc_r <= 1'b0;
                end
            end

            // autoretry period timer and counter
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) auto_cnt_r <= '0;
                else if (!latched || retry_fire) auto_cnt_r <= '0;
                else if (auto_cnt_r != AUTO_LAST) auto_cnt_r <= auto_cnt_r + 1'b1;
            end
            // count holds at the limit; only a mode change or a wipe starts it again
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) retry_count[g] <= '0;
                else if (wipe || mode_change) retry_count[g] <= '0;
                else if (retry_fire) retry_count[g] <= retry_count[g] + 5'h01;
            end

            // off-time counter feeds the cooling emulator
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) off_cnt_r <= '1;
                else if (output_enable[g]) off_cnt_r <= '0;
                else if (off_cnt_r != 16'hffff) off_cnt_r <= off_cnt_r + 16'h0001;
            end

            // first inrush step: longer off means a colder filament and a higher step
            always_comb begin
                first_step = ch_cfg[g].inrush_top_step_remove ? SFPM_LVL_SKIP : SFPM_LVL_TOP;
                if (!failsafe_mode && pwm_enable && internal_pwm_select && !retry_fire
                    && ch_cfg[g].cooling_emulation_enable && ch_cfg[g].hid_profile_select) begin
                    if (off_cnt_r < 16'(SFPM_COOL_BASE << ch_cfg[g].cooling_slope_select))
                        first_step = STEP_HOT;
                    else if (off_cnt_r < 16'(SFPM_COOL_BASE << ({1'b0, ch_cfg[g].cooling_slope_select} + 3'h1)))
                        first_step = STEP_WARM;
                end
                // a bulb profile never starts above its own top step on a command rise
                if (first_step < prof_ofs) first_step = prof_ofs;
                case (ch_cfg[g].steady_level_select)
                    2'h1: steady_lvl = SFPM_LVL_DC1;
                    2'h2: steady_lvl = SFPM_LVL_DC3;
                    2'h3: steady_lvl = SFPM_LVL_DC4;
                    default: steady_lvl = SFPM_LVL_DC2;
                endcase
            end
            // dwell per step doubles with each slope code
            assign dwell_len = 12'(SFPM_STEP_BASE << ch_cfg[g].inrush_slope);
            assign stable_on = output_enable[g];

            // inrush step sequencer; a retry restarts from the default profile
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    inrush_r <= 1'b0;
                    step_r <= SFPM_LVL_TOP;
                    dwell_r <= '0;
                end else if (rise || retry_fire) begin
                    inrush_r <= 1'b1;
                    step_r <= retry_fire ? SFPM_LVL_TOP : first_step;
                    dwell_r <= '0;
                end else if (inrush_r && stable_on) begin
                    if (dwell_r >= dwell_len - 12'h001) begin
                        dwell_r <= '0;
                        if (step_r >= 3'h3) inrush_r <= 1'b0;
                        else step_r <= step_r + 3'h1;
                    end else begin
                        dwell_r <= dwell_r + 12'h001;
                    end
                end
            end

            // profile offset: hid with the select low (default), 55 W or 28 W bulb with it set
            assign prof_ofs = !ch_cfg[g].hid_profile_select ? 3'h0 : (ch_cfg[g].bulb28_select ? 3'h2 : 3'h1);
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) oc_level_index[g] <= SFPM_LVL_TOP;
                else oc_level_index[g] <= inrush_r ? step_r : steady_lvl;
            end

            // output gate and fault-pin contribution
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) output_enable[g] <= 1'b0;
                else output_enable[g] <= cmd[g] && !latched && !ov_shut && !uv_s
                                         && !det[g].overtemp && !wipe;
            end
            assign pin_low[g] = lat_ot_r || lat_oc_r || lat_sc_r || det[g].overtemp
                              || (uv_lat_r && cmd[g])
                              || (!cmd[g] && det[g].gate_off
                                  && ((det[g].short_to_supply && !ch_cfg[g].short_to_supply_disable)
                                      || (det[g].off_openload && !ch_cfg[g].off_openload_disable)));

            // per-channel reporting flags; a new event wins over the read clear
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) ch_stat[g] <= '0;
                else if (wipe) ch_stat[g] <= '0;
                else begin
                    if (det[g].overtemp) ch_stat[g].overtemp_flag <= 1'b1;
                    else if (status_read) ch_stat[g].overtemp_flag <= 1'b0;
                    if (det[g].overcurrent && output_enable[g]) ch_stat[g].overcurrent_flag <= 1'b1;
                    else if (status_read) ch_stat[g].overcurrent_flag <= 1'b0;
                    if (det[g].severe_short && output_enable[g]) ch_stat[g].severe_short_flag <= 1'b1;
                    else if (status_read) ch_stat[g].severe_short_flag <= 1'b0;
                    if (!cmd[g] && det[g].gate_off && det[g].short_to_supply && !ch_cfg[g].short_to_supply_disable) begin
                        ch_stat[g].short_to_supply_flag <= 1'b1;
                        ch_stat[g].off_openload_flag <= 1'b1;
                    end else if (!cmd[g] && det[g].gate_off && det[g].off_openload
                                 && !ch_cfg[g].off_openload_disable) begin
                        ch_stat[g].off_openload_flag <= 1'b1;
                    end else if (status_read) begin
                        ch_stat[g].short_to_supply_flag <= 1'b0;
                        ch_stat[g].off_openload_flag <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // active-low fault pin, registered
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) fault_flag_out_n <= 1'b1;
        else fault_flag_out_n <= !((|pin_low) || ov_shut || uv_s);
    end
endmodule // sfpm_top

// file: sim/sfpm_mcu_model.sv
// microcontroller model issuing status reads
`timescale 1ns/1ps
module sfpm_mcu_model (
    input wire logic sys_clk,
    output logic status_read
);
    initial status_read = 1'b0;
    // one-cycle read strobe, moved only off the sampling edge
    task automatic read_status();
        @(negedge sys_clk);
        status_read = 1'b1;
        @(negedge sys_clk);
        status_read = 1'b0;
    endtask
endmodule // sfpm_mcu_model

// file: sim/sfpm_props.sv
// assertion checker for the fault protection manager
`timescale 1ns/1ps
module sfpm_props
    import sfpm_pkg::*;
#(
    parameter int unsigned NCH = 4,
    parameter int unsigned AUTO_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic logic_supply_fail,
    input wire logic failsafe_mode,
    input wire logic overvoltage_protect_disable,
    input wire sfpm_ch_det_t [NCH-1:0] ch_det,
    input wire logic status_read,
    input wire logic [NCH-1:0] output_enable,
    input wire logic fault_flag_out_n,
    input wire sfpm_ch_stat_t [NCH-1:0] ch_stat,
    input wire logic overvoltage_flag,
    input wire logic undervoltage_flag,
    input wire logic [NCH-1:0][4:0] retry_count
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // overheat absent long enough that the synchroniser holds nothing
    sequence ot_quiet;
        (!ch_det[0].overtemp)[*5];
    endsequence
    // severe short keeps the gate off, no retry can sneak in
    sequence sc_held;
        (!output_enable[2])[*8];
    endsequence
    a_ot_pin_low: assert property ($rose(ch_stat[0].overtemp_flag) |=> !fault_flag_out_n)
        else $error("pin not low after overheat");
    // the gate register drops one edge after the latch and the flag
    a_oc_gate_off: assert property ($rose(ch_stat[1].overcurrent_flag) |=> ##1 !output_enable[1])
        else $error("output on after overcurrent");
    a_sc_stays_off: assert property ($rose(ch_stat[2].severe_short_flag) |=> ##1 sc_held)
        else $error("output on after severe short");
    a_ov_all_off: assert property ($rose(overvoltage_flag) && !overvoltage_protect_disable
        |=> output_enable == '0 && !fault_flag_out_n)
        else $error("outputs on during overvoltage");
    a_uv_all_off: assert property ($rose(undervoltage_flag) |=> output_enable == '0 && !fault_flag_out_n)
        else $error("outputs on during undervoltage");
    a_ot_read_clear: assert property (ot_quiet ##0 status_read |=> !ch_stat[0].overtemp_flag)
        else $error("overheat flag kept after read");
    a_retry_max: assert property (retry_count[2] <= 5'h10)
        else $error("retry count above limit");
    a_mode_clear: assert property ($changed(failsafe_mode) |-> ##[1:3] retry_count == '0)
        else $error("retry count kept over mode change");
    a_supply_wipe: assert property (logic_supply_fail |=> retry_count == '0 && !undervoltage_flag)
        else $error("state kept during logic supply fail");
endmodule // sfpm_props
bind sfpm_top sfpm_props #(.NCH(NCH), .AUTO_CYC(AUTO_CYC)) i_props (
    .sys_clk(sys_clk), .rstn(rstn), .logic_supply_fail(logic_supply_fail), .failsafe_mode(failsafe_mode),
    .overvoltage_protect_disable(overvoltage_protect_disable), .ch_det(ch_det), .status_read(status_read),
    .output_enable(output_enable), .fault_flag_out_n(fault_flag_out_n), .ch_stat(ch_stat),
    .overvoltage_flag(overvoltage_flag), .undervoltage_flag(undervoltage_flag), .retry_count(retry_count)
);

// file: sim/sfpm_tb_top.sv
// self-checking testbench for the fault protection manager
`timescale 1ns/1ps
module sfpm_tb_top;
    import sfpm_pkg::*;
    localparam int unsigned NCH = 4;
    // short retry period keeps the sixteen-retry run brief
    localparam int unsigned AUTO = 40;
    // run needs about 4000 cycles; allow five times that
    localparam int unsigned WD_NS = 20000 * 50;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic logic_supply_fail = 1'b0;
    logic [NCH-1:0] on_input = '0;
    logic failsafe_mode = 1'b0;
    logic overvoltage_protect_disable = 1'b0;
    logic pwm_enable = 1'b0;
    logic internal_pwm_select = 1'b0;
    sfpm_ch_cfg_t [NCH-1:0] ch_cfg = '0;
    sfpm_ch_det_t [NCH-1:0] ch_det = '0;
    logic overvoltage_det = 1'b0;
    logic undervoltage_det = 1'b0;
    logic status_read;
    logic [NCH-1:0] output_enable;
    logic [NCH-1:0][2:0] oc_level_index;
    logic fault_flag_out_n;
    sfpm_ch_stat_t [NCH-1:0] ch_stat;
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic [NCH-1:0][4:0] retry_count;
    int errors = 0;
    int checked = 0;

    always #25 sys_clk = ~sys_clk;

    sfpm_top #(.NCH(NCH), .AUTO_CYC(AUTO)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .logic_supply_fail(logic_supply_fail), .on_input(on_input),
        .pwm_enable(pwm_enable), .internal_pwm_select(internal_pwm_select), .failsafe_mode(failsafe_mode),
        .overvoltage_protect_disable(overvoltage_protect_disable), .ch_cfg(ch_cfg), .ch_det(ch_det),
        .overvoltage_det(overvoltage_det), .undervoltage_det(undervoltage_det), .status_read(status_read),
        .output_enable(output_enable), .oc_level_index(oc_level_index), .fault_flag_out_n(fault_flag_out_n),
        .ch_stat(ch_stat), .overvoltage_flag(overvoltage_flag), .undervoltage_flag(undervoltage_flag),
        .retry_count(retry_count)
    );
    sfpm_mcu_model i_mcu (.sys_clk(sys_clk), .status_read(status_read));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic rd();
        i_mcu.read_status();
    endtask
    task automatic stop_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // latching fault f (0 heat, 1 current, 2 severe short) on commanded channel k
    task automatic latch_test(input int k, input int f);
        ch_det[k][5-f] = 1'b1;
        cyc(6);
        chk("latch oe", output_enable[k], 1'b0);
        chk("latch pin", fault_flag_out_n, 1'b0);
        chk("latch flag", ch_stat[k][4-f], 1'b1);
        ch_det[k][5-f] = 1'b0;
        cyc(8);
        chk("latch held", fault_flag_out_n, 1'b0);
        rd();
        chk("latch read", ch_stat[k][4-f], 1'b0);
        if (f == 2) cyc(AUTO + 10);
        chk("no retry", output_enable[k], 1'b0);
        on_input[k] = 1'b0;
        cyc(2);
        on_input[k] = 1'b1;
        cyc(6);
        chk("toggle oe", output_enable[k], 1'b1);
        chk("toggle pin", fault_flag_out_n, 1'b1);
        $display("test latch %0d done", f);
    endtask
    // off-channel fault: pin follows the condition, flags wait for a read
    task automatic off_test(input int b, input logic [4:0] fl, input logic pin);
        ch_det[3][b] = 1'b1;
        cyc(6);
        chk("off flags", ch_stat[3], fl);
        chk("off pin", fault_flag_out_n, pin);
        ch_det[3][b] = 1'b0;
        cyc(6);
        chk("off kept", ch_stat[3], fl);
        chk("off pin back", fault_flag_out_n, 1'b1);
        rd();
        chk("off read", ch_stat[3], 5'h00);
        $display("test off %0d done", b);
    endtask

    // main sequence
    initial begin
        cyc(5);
        rstn = 1'b1;
        cyc(2);
        chk("rst pin", fault_flag_out_n, 1'b1);
        chk("rst flags", ch_stat, '0);
        ch_det[3].gate_off = 1'b1;
        on_input = 4'h7;
        ch_cfg[1].direct_disable = 1'b1;
        cyc(6);
        chk("direct gated", output_enable, 4'h5);
        ch_cfg[1].direct_disable = 1'b0;
        cyc(6);
        for (int f = 0; f < 3; f++) latch_test(f, f);
        cyc(1100);
        chk("steady level", oc_level_index[0], SFPM_LVL_DC2);
        off_test(5, 5'h10, 1'b0);
        off_test(2, 5'h03, 1'b0);
        off_test(1, 5'h01, 1'b0);
        ch_cfg[3].short_to_supply_disable = 1'b1;
        ch_cfg[3].off_openload_disable = 1'b1;
        off_test(2, 5'h00, 1'b1);
        off_test(1, 5'h00, 1'b1);
        overvoltage_det = 1'b1;
        cyc(6);
        chk("ov off", output_enable, 4'h0);
        chk("ov flag", overvoltage_flag, 1'b1);
        overvoltage_det = 1'b0;
        cyc(6);
        chk("ov back", output_enable, 4'h7);
        rd();
        chk("ov read", overvoltage_flag, 1'b0);
        overvoltage_protect_disable = 1'b1;
        overvoltage_det = 1'b1;
        cyc(6);
        chk("ov warn oe", output_enable, 4'h7);
        rd();
        chk("ov warn held", overvoltage_flag, 1'b1);
        overvoltage_det = 1'b0;
        cyc(6);
        rd();
        chk("ov warn read", overvoltage_flag, 1'b0);
        on_input = 4'h0;
        undervoltage_det = 1'b1;
        cyc(6);
        chk("uv pin", fault_flag_out_n, 1'b0);
        undervoltage_det = 1'b0;
        cyc(6);
        chk("uv pin free", fault_flag_out_n, 1'b1);
        chk("uv kept", undervoltage_flag, 1'b1);
        on_input = 4'h1;
        logic_supply_fail = 1'b1;
        cyc(3);
        logic_supply_fail = 1'b0;
        cyc(6);
        chk("wipe flag", undervoltage_flag, 1'b0);
        chk("wipe oe", output_enable, 4'h1);
        $display("test supply done");
        on_input = 4'h4;
        // each restart is met by a short overcurrent pulse until retries run out
        for (int i = 0; i < 18; i++) begin
            for (int w = 0; w < AUTO + 20 && output_enable[2] !== 1'b1; w++) cyc(1);
            if (i == 1) chk("retry inrush", oc_level_index[2][2], 1'b0);
            ch_det[2].overcurrent = 1'b1;
            cyc(5);
            ch_det[2].overcurrent = 1'b0;
        end
        chk("retry limit", retry_count[2], 5'h10);
        chk("retry stop", output_enable[2], 1'b0);
        failsafe_mode = 1'b1;
        cyc(4);
        chk("mode reset", retry_count[2], 5'h00);
        $display("test retry done");
        // pwm drive: on bits rule the command; off time and profile pick the first step
        failsafe_mode = 1'b0;
        pwm_enable = 1'b1;
        internal_pwm_select = 1'b1;
        ch_cfg[3].hid_profile_select = 1'b1;
        ch_cfg[3].on_bit = 1'b1;
        cyc(4);
        chk("pwm on bit", output_enable, 4'h8);
        for (int j = 0; j < 3; j++) begin
            ch_cfg[3].on_bit = 1'b0;
            cyc(j == 1 ? 1500 : 100);
            ch_cfg[3].cooling_emulation_enable = (j < 2);
            ch_cfg[3].bulb28_select = (j == 2);
            ch_cfg[3].on_bit = 1'b1;
            cyc(4);
            chk("first step", oc_level_index[3], (j == 0) ? 3'h3 : 3'h2);
        end
        $display("test pwm done");
        stop_test();
    end

    // watchdog against a hang
    initial begin
        #(WD_NS);
        errors++;
        stop_test();
    end
endmodule // sfpm_tb_top
